//--- rtl/slpa_params.svh
/*
  offsets, field positions, reset values and address constants of the
  stack limit and program space address generator.
  assumes a byte-addressed register port with 16-bit data.
*/
`ifndef SLPA_PARAMS_SVH
`define SLPA_PARAMS_SVH
`define SLPA_OFS_SP 8'h00
`define SLPA_OFS_LIMIT 8'h04
`define SLPA_OFS_TABLE_PAGE_REG 8'h08
`define SLPA_OFS_VISPAG 8'h0C
`define SLPA_OFS_CORE 8'h10
`define SLPA_OFS_STAT 8'h14
`define SLPA_OFS_CLR 8'h18
`define SLPA_OFS_EN 8'h1C
`define SLPA_SP_RST 16'h0800
`define SLPA_SFR_TOP 16'h0800
`define SLPA_WORD_STEP 16'h0002
`define SLPA_VIS_PROG 8'h00
`define SLPA_VIS_EEPROM 8'hFF
`define SLPA_CORE_WIN_BIT 2
`define SLPA_CFG_BIT 7
`define SLPA_STAT_OVF 0
`define SLPA_STAT_UDF 1
`endif

//--- rtl/slpa_pkg.sv
/*
  types shared by the stack and program space address logic.
  assumes the constants of slpa_params.svh.
*/
package slpa_pkg;
  typedef enum logic [0:0] {
    SLPA_ST_IDLE = 1'h0,
    SLPA_ST_HI = 1'h1
  } slpa_stk_e;
  typedef logic [15:0] slpa_word_t;
  typedef logic [23:0] slpa_paddr_t;
endpackage

//--- rtl/slpa_pg_if.sv
/*
  carrier between the top and the program address former.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
interface slpa_pg_if (
  input wire logic clk,
  input wire logic sys_rst
);
  slpa_pkg::slpa_word_t ea;
  logic data_rd;
  logic tbl_rd;
  logic tbl_wr;
  logic win_en;
  logic [7:0] tbl_page;
  logic [7:0] vis_page;
  slpa_pkg::slpa_paddr_t addr;
  logic rd;
  logic wr;
  logic cfg;
  logic win;
  modport ctl (input clk, sys_rst, addr, rd, wr, cfg, win,
    output ea, data_rd, tbl_rd, tbl_wr, win_en, tbl_page, vis_page);
  modport agu (input clk, sys_rst, ea, data_rd, tbl_rd, tbl_wr, win_en, tbl_page,
    vis_page, output addr, rd, wr, cfg, win);
endinterface

//--- rtl/slpa_pgaddr.sv
/*
  forms 24-bit program addresses for table and window accesses.
  assumes requests arrive one per cycle from the execution pipeline.
*/
`timescale 1ns/1ps
`include "slpa_params.svh"
module slpa_pgaddr (
  slpa_pg_if.agu pg
);
  wire win_hit;
  wire tbl_any;
  assign tbl_any = pg.tbl_rd | pg.tbl_wr;
  // window paused while a table access runs enable bit gates it
  assign win_hit = pg.data_rd & pg.ea[15] & pg.win_en & ~tbl_any;
  // no alignment check: byte and odd addresses pass as given
  // data 16 bits, program 24 bits
  assign pg.addr = tbl_any ? {pg.tbl_page, pg.ea}
    : {1'b0, pg.vis_page, pg.ea[14:0]};
  assign pg.cfg = tbl_any & pg.tbl_page[`SLPA_CFG_BIT];
  assign pg.rd = pg.tbl_rd | win_hit;
  // config space takes reads only
  assign pg.wr = pg.tbl_wr & ~pg.tbl_page[`SLPA_CFG_BIT];
  assign pg.win = win_hit;

  default clocking cb @(posedge pg.clk); endclocking
  default disable iff (pg.sys_rst);
  a_win_addr_form: assert property (pg.win |-> pg.addr[23] == 1'b0 &&
    pg.addr[15] == pg.vis_page[0] && pg.addr[14:0] == pg.ea[14:0])
    else $error("window address badly formed");
  a_tbl_addr_form: assert property (pg.tbl_rd |-> pg.addr == {pg.tbl_page, pg.ea} &&
    pg.cfg == pg.tbl_page[7])
    else $error("table address badly formed");
  a_win_paused_tbl: assert property (pg.tbl_wr |-> !pg.win)
    else $error("window active during table write");
endmodule

//--- rtl/slpa_top.sv
/*
  stack pointer push/pop with limit and floor traps, program space address
  generation, register port and interrupt.
  assumes one clock, at most one stack request per cycle, and no new
  request while a two-word return address push is in progress.
*/
// Decided for this implementation: the address-and-strobe port and the register addresses.
// Operation
// - stack pointer names next free word; post-increment push, pre-decrement pop
// - call pushes return address with its top byte cleared
// - exception push puts status low byte in the top byte
// - stack limit unset by reset, bit 0 always reads zero
// - push at pointer equal to limit passes; push above limit traps
// - stack address below 0x0800 raises stack error
// - table address is page byte above 16-bit effective address
// - page bit 7 picks configuration space, else user space
// - upper-half data read maps to 23-bit window address
// - window ignores address bit 15, uses page bit 0, bit 23 zero
// - visibility page accepts only 0x00 or 0xFF
// - table accesses need no alignment; config space readable
// - window is read-only and returns low program word only
// - program space 24 bits, data space 16 bits
// - window active only with core control bit 2 set
// - window suspended during table reads and writes
`timescale 1ns/1ps
`include "slpa_params.svh"
module slpa_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic push_req,
  input wire logic [15:0] push_data,
  input wire logic pop_req,
  input wire logic call_push,
  input wire logic exc_push,
  input wire logic [22:0] pc_val,
  input wire logic [7:0] status_low_byte,
  output logic stk_mem_wr,
  output logic stk_mem_rd,
  output logic [15:0] stk_mem_addr,
  output logic [15:0] stk_mem_wdata,
  output logic stack_trap,
  output logic irq,
  input wire logic [15:0] effective_address,
  input wire logic data_rd,
  input wire logic tbl_rd,
  input wire logic tbl_wr,
  input wire logic [23:0] prog_rdata,
  output logic [23:0] prog_addr,
  output logic prog_rd,
  output logic prog_wr,
  output logic cfg_space,
  output logic win_valid,
  output logic [15:0] win_rdata
);
  function automatic logic below_floor(input logic [15:0] a);
    below_floor = a < `SLPA_SFR_TOP;
  endfunction

  slpa_pkg::slpa_stk_e st_reg, st_next;
  logic [15:0] stack_pointer_reg, sp_next;
  logic [14:0] stack_limit_reg;
  logic [7:0] table_page_reg, visibility_page_reg;
  logic program_window_enable;
  logic [7:0] msb_reg;
  logic [6:0] pc_hi_reg;
  logic [1:0] stat_reg, en_reg, stat_next;
  logic win_pend_reg;

  slpa_pg_if pg (.clk(clk), .sys_rst(sys_rst));
  slpa_pgaddr u_pgaddr (.pg(pg.agu));
  assign pg.ea = effective_address;
  assign pg.data_rd = data_rd;
  assign pg.tbl_rd = tbl_rd;
  assign pg.tbl_wr = tbl_wr;
  assign pg.win_en = program_window_enable;
  assign pg.tbl_page = table_page_reg;
  assign pg.vis_page = visibility_page_reg;

  wire [15:0] limit16 = {stack_limit_reg, 1'b0};
  wire in_hi = st_reg == slpa_pkg::SLPA_ST_HI;
  wire pc_req = ~in_hi & (call_push | exc_push);
  wire push_op = in_hi | pc_req | (~in_hi & push_req);
  wire pop_op = ~in_hi & pop_req & ~push_req & ~call_push & ~exc_push;
  wire [15:0] pop_addr = stack_pointer_reg - `SLPA_WORD_STEP;
  // equal to limit still passes; only strictly above traps
  wire push_err = (stack_pointer_reg > limit16) | below_floor(stack_pointer_reg);
  // pop checks both the word it would read and the pointer itself
  wire pop_err = below_floor(pop_addr) | below_floor(stack_pointer_reg);
  wire trap_now = (push_op & push_err) | (pop_op & pop_err);
  // failing access is dropped, pointer held
  wire wr_ok = push_op & ~push_err;
  wire rd_ok = pop_op & ~pop_err;
  // call clears top byte exception inserts status byte
  wire [7:0] msb_sel = exc_push & ~call_push ? status_low_byte : 8'h00;
  wire [15:0] wdata_sel = in_hi ? {msb_reg, 1'b0, pc_hi_reg}
    : pc_req ? pc_val[15:0] : push_data;
  wire [15:0] addr_sel = pop_op ? pop_addr : stack_pointer_reg;

  always_comb begin
    sp_next = stack_pointer_reg;
    st_next = st_reg;
    case (st_reg)
      slpa_pkg::SLPA_ST_IDLE: begin
        if (wr_ok) begin
          sp_next = stack_pointer_reg + `SLPA_WORD_STEP;
        end else if (rd_ok) begin
          sp_next = pop_addr;
        end
        if (pc_req & ~push_err) begin
          st_next = slpa_pkg::SLPA_ST_HI;
        end
      end
      slpa_pkg::SLPA_ST_HI: begin
        if (wr_ok) begin
          sp_next = stack_pointer_reg + `SLPA_WORD_STEP;
        end
        st_next = slpa_pkg::SLPA_ST_IDLE;
      end
      default: begin
        st_next = slpa_pkg::SLPA_ST_IDLE;
      end
    endcase
  end

  wire wr_sp = reg_wr & (reg_addr == `SLPA_OFS_SP);
  wire wr_lim = reg_wr & (reg_addr == `SLPA_OFS_LIMIT);
  wire wr_tbl = reg_wr & (reg_addr == `SLPA_OFS_TABLE_PAGE_REG);
  wire vis_legal = reg_wdata[7:0] == `SLPA_VIS_PROG || reg_wdata[7:0] == `SLPA_VIS_EEPROM;
  // other page values are dropped
  wire wr_vis = reg_wr & (reg_addr == `SLPA_OFS_VISPAG) & vis_legal;
  wire wr_core = reg_wr & (reg_addr == `SLPA_OFS_CORE);
  wire wr_clr = reg_wr & (reg_addr == `SLPA_OFS_CLR);
  wire wr_en = reg_wr & (reg_addr == `SLPA_OFS_EN);
  wire [1:0] ev = {pop_op & pop_err, push_op & push_err & ~below_floor(stack_pointer_reg)};
  wire [1:0] ev_udf = {push_op & below_floor(stack_pointer_reg), 1'b0};
  // set beats clear in the same cycle
  assign stat_next = (stat_reg & ~(wr_clr ? reg_wdata[1:0] : 2'h0)) | ev | ev_udf;
  // stack engine owns the pointer when both try
  wire sp_bus = wr_sp & ~push_op & ~pop_op;
  wire [15:0] rd_mux =
    reg_addr == `SLPA_OFS_SP ? stack_pointer_reg :
    reg_addr == `SLPA_OFS_LIMIT ? limit16 :
    reg_addr == `SLPA_OFS_TABLE_PAGE_REG ? {8'h00, table_page_reg} :
    reg_addr == `SLPA_OFS_VISPAG ? {8'h00, visibility_page_reg} :
    reg_addr == `SLPA_OFS_CORE ? 16'(program_window_enable) << `SLPA_CORE_WIN_BIT :
    reg_addr == `SLPA_OFS_STAT ? {14'h0000, stat_reg} :
    reg_addr == `SLPA_OFS_EN ? {14'h0000, en_reg} : 16'h0000;

  // no reset term: limit is undefined until software writes it
  always_ff @(posedge clk) begin
    if (wr_lim) begin
      stack_limit_reg <= reg_wdata[15:1];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= slpa_pkg::SLPA_ST_IDLE;
      stack_pointer_reg <= `SLPA_SP_RST;
      msb_reg <= 8'h00;
      pc_hi_reg <= 7'h00;
    end else begin
      st_reg <= st_next;
      stack_pointer_reg <= sp_bus ? {reg_wdata[15:1], 1'b0} : sp_next;
      if (pc_req) begin
        msb_reg <= msb_sel;
        pc_hi_reg <= pc_val[22:16];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      table_page_reg <= 8'h00;
      visibility_page_reg <= `SLPA_VIS_PROG;
      program_window_enable <= 1'b0;
      stat_reg <= 2'h0;
      en_reg <= 2'h0;
      irq <= 1'b0;
      reg_rdata <= 16'h0000;
    end else begin
      if (wr_tbl) begin
        table_page_reg <= reg_wdata[7:0];
      end
      if (wr_vis) begin
        visibility_page_reg <= reg_wdata[7:0];
      end
      if (wr_core) begin
        program_window_enable <= reg_wdata[`SLPA_CORE_WIN_BIT];
      end
      if (wr_en) begin
        en_reg <= reg_wdata[1:0];
      end
      stat_reg <= stat_next;
      // enable written this cycle counts at once, so irq never lags a write
      irq <= |(stat_next & (wr_en ? reg_wdata[1:0] : en_reg));
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stk_mem_wr <= 1'b0;
      stk_mem_rd <= 1'b0;
      stk_mem_addr <= 16'h0000;
      stk_mem_wdata <= 16'h0000;
      stack_trap <= 1'b0;
    end else begin
      stk_mem_wr <= wr_ok;
      stk_mem_rd <= rd_ok;
      stk_mem_addr <= addr_sel;
      stk_mem_wdata <= wdata_sel;
      stack_trap <= trap_now;
    end
  end

  // window data comes back the cycle after the read; upper byte dropped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prog_addr <= 24'h000000;
      prog_rd <= 1'b0;
      prog_wr <= 1'b0;
      cfg_space <= 1'b0;
      win_pend_reg <= 1'b0;
      win_valid <= 1'b0;
      win_rdata <= 16'h0000;
    end else begin
      prog_addr <= pg.addr;
      prog_rd <= pg.rd;
      prog_wr <= pg.wr;
      cfg_space <= pg.cfg;
      win_pend_reg <= pg.win;
      win_valid <= win_pend_reg;
      win_rdata <= win_pend_reg ? prog_rdata[15:0] : 16'h0000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_pc_req_ok;
    pc_req && !push_err && !(stack_pointer_reg + 16'h0002 > limit16);
  endsequence
  sequence s_two_writes;
    stk_mem_wr ##1 stk_mem_wr;
  endsequence
  a_push_at_limit: assert property (push_op && !in_hi && !pc_req &&
    stack_pointer_reg == limit16 && !below_floor(stack_pointer_reg)
    |=> !stack_trap && stk_mem_wr && stack_pointer_reg == $past(stack_pointer_reg) + 16'h0002)
    else $error("push at limit must pass and advance");
  a_push_over_limit: assert property (push_op && stack_pointer_reg > limit16
    |=> stack_trap && !stk_mem_wr && $stable(stack_pointer_reg))
    else $error("push above limit must trap and be dropped");
  a_floor_trap: assert property (pop_op && pop_addr < 16'h0800
    |=> stack_trap && !stk_mem_rd && stat_reg[1])
    else $error("pop below floor must trap and flag");
  a_pop_predec: assert property (rd_ok
    |=> stk_mem_rd && stk_mem_addr == stack_pointer_reg)
    else $error("pop must read the pre-decremented word");
  a_call_msb_zero: assert property (s_pc_req_ok and call_push
    |=> s_two_writes ##0 stk_mem_wdata[15:7] == 9'h000)
    else $error("call push top byte not clear");
  a_exc_msb_byte: assert property (s_pc_req_ok and exc_push && !call_push
    |=> s_two_writes ##0 stk_mem_wdata[15:8] == $past(status_low_byte, 2))
    else $error("exception push lacks status byte");
  a_limit_even: assert property (reg_rd && reg_addr == 8'h04
    |=> reg_rdata[0] == 1'b0)
    else $error("limit bit 0 not zero");
  a_vis_two_vals: assert property (visibility_page_reg == 8'h00 ||
    visibility_page_reg == 8'hFF)
    else $error("visibility page holds illegal value");
  a_win_gate: assert property (data_rd && effective_address[15] && !tbl_rd && !tbl_wr
    |=> prog_rd == $past(program_window_enable) ##1 win_valid == $past(program_window_enable, 2))
    else $error("window not gated by enable bit");

  // flags are checked on the trap edge itself; a clear one cycle later is legal
  sequence s_pc_words;
    stk_mem_wr && !stack_trap ##1 stk_mem_wr && stk_mem_addr == $past(stk_mem_addr) + 16'h0002;
  endsequence
  a_pc_two_words: assert property (s_pc_req_ok |=> s_pc_words)
    else $error("return address words not at consecutive slots");
  a_trap_drops_access: assert property (stack_trap |-> !stk_mem_wr && !stk_mem_rd)
    else $error("trapped access still reached stack memory");
  a_push_post_inc: assert property (wr_ok |=> stk_mem_wr &&
    stk_mem_addr == $past(stack_pointer_reg) &&
    stack_pointer_reg == $past(stack_pointer_reg) + 16'h0002)
    else $error("push must write at the pointer and then advance");
  a_floor_push_trap: assert property (push_op && below_floor(stack_pointer_reg)
    |=> stack_trap && !stk_mem_wr && stat_reg[1])
    else $error("push below floor must trap and flag");
  a_vis_drop_bad: assert property (reg_wr && !vis_legal &&
    reg_addr == `SLPA_OFS_VISPAG |=> $stable(visibility_page_reg))
    else $error("illegal visibility page value was stored");
  a_irq_follows: assert property (irq == |(stat_reg & en_reg))
    else $error("interrupt line disagrees with enabled status");
endmodule

//--- testbench/slpa_prog_mem.sv
/*
  program memory model standing behind the program address outputs.
  assumes prog_rd is a one-cycle pulse and that the data is sampled at the clock edge that ends it.
*/
`timescale 1ns/1ps
module slpa_prog_mem (
  input wire logic clk,
  input wire logic [23:0] prog_addr,
  input wire logic prog_rd,
  output logic [23:0] prog_rdata
);
  logic flip_reg = 1'b0;
  // undriven bus toggles each cycle, so stale data never passes for a match
  always_ff @(posedge clk) begin
    flip_reg <= ~flip_reg;
  end
  // content is derived from address bits 15:0, so a wrong low address gives wrong data
  assign prog_rdata = prog_rd ? {prog_addr[7:0], ~prog_addr[15:0]} : {24{flip_reg}};
endmodule

//--- testbench/tb.sv
/*
  self-checking bench: register port, stack, trap, interrupt and program address checks.
  assumes slpa_top, slpa_params.svh and the program memory model.
*/
`timescale 1ns/1ps
`include "slpa_params.svh"
module tb;
  logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic push_req = 1'b0, pop_req = 1'b0, call_push = 1'b0, exc_push = 1'b0;
  logic data_rd = 1'b0, tbl_rd = 1'b0, tbl_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00, status_low_byte = 8'hC3;
  logic [15:0] reg_wdata = 16'h0000, push_data = 16'hA5C3, effective_address = 16'h0000;
  logic [22:0] pc_val = 23'h7ABCDE;
  logic [23:0] prog_rdata, prog_addr;
  logic [15:0] reg_rdata, stk_mem_addr, stk_mem_wdata, win_rdata;
  logic stk_mem_wr, stk_mem_rd, stack_trap, irq, prog_rd, prog_wr, cfg_space, win_valid;
  int failures = 0;
  int comparisons = 0;

  always #50 clk = ~clk;

  slpa_top i_dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .push_req, .push_data, .pop_req, .call_push, .exc_push, .pc_val, .status_low_byte,
    .stk_mem_wr, .stk_mem_rd, .stk_mem_addr, .stk_mem_wdata, .stack_trap, .irq,
    .effective_address, .data_rd, .tbl_rd, .tbl_wr, .prog_rdata, .prog_addr, .prog_rd,
    .prog_wr, .cfg_space, .win_valid, .win_rdata);
  slpa_prog_mem i_mem (.clk, .prog_addr, .prog_rd, .prog_rdata);

  task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, reg_rdata, exp);
  endtask

  // k = {exc, call, pop, push}; f = expected {wr, rd, trap}
  task automatic sk(input string what, input logic [3:0] k, input logic [2:0] f,
    input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    {exc_push, call_push, pop_req, push_req} <= k;
    @(posedge clk);
    {exc_push, call_push, pop_req, push_req} <= 4'h0;
    #1;
    chk(what, {stk_mem_wr, stk_mem_rd, stack_trap}, f);
    if (f[2:1] != 2'h0) chk(what, stk_mem_addr, a);
    if (f[2]) chk(what, stk_mem_wdata, d);
  endtask

  task automatic nx(input string what, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    chk(what, {stk_mem_wr, stack_trap, stk_mem_addr, stk_mem_wdata}, {2'h2, a, d});
  endtask

  // k = {data_rd, tbl_rd, tbl_wr}; f = expected {prog_rd, prog_wr, cfg_space}
  task automatic pg(input string what, input logic [2:0] k, input logic [15:0] ea,
    input logic [2:0] f, input logic [23:0] a);
    @(posedge clk);
    {data_rd, tbl_rd, tbl_wr} <= k;
    effective_address <= ea;
    @(posedge clk);
    {data_rd, tbl_rd, tbl_wr} <= 3'h0;
    #1;
    chk(what, {prog_rd, prog_wr}, f[2:1]);
    if (f[2:1] != 2'h0) chk(what, {cfg_space, prog_addr}, {f[0], a});
  endtask

  task automatic results;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // tests need about 100 cycles; 3000 leaves a wide margin
  initial begin
    #300000;
    failures++;
    results();
  end

  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd("sp_rst", `SLPA_OFS_SP, 16'h0800);
    rd("unmapped", 8'h20, 16'h0000);
    wr(`SLPA_OFS_LIMIT, 16'h0803);
    // only a register read follows the limit write
    rd("limit", `SLPA_OFS_LIMIT, 16'h0802);
    wr(`SLPA_OFS_EN, 16'h0003);
    sk("push0", 4'h1, 3'h4, 16'h0800, 16'hA5C3);
    sk("push_eq", 4'h1, 3'h4, 16'h0802, 16'hA5C3);
    sk("push_ovf", 4'h1, 3'h1, 16'h0000, 16'h0000);
    @(posedge clk);
    #1;
    chk("trap_len", {stack_trap, stk_mem_wr}, 2'h0);
    rd("sp_held", `SLPA_OFS_SP, 16'h0804);
    rd("stat_ovf", `SLPA_OFS_STAT, 16'h0001);
    chk("irq_on", irq, 1'b1);
    wr(`SLPA_OFS_EN, 16'h0000);
    rd("en_off", `SLPA_OFS_EN, 16'h0000);
    chk("irq_mask", irq, 1'b0);
    wr(`SLPA_OFS_CLR, 16'h0003);
    wr(`SLPA_OFS_EN, 16'h0003);
    rd("stat_clr", `SLPA_OFS_STAT, 16'h0000);
    sk("pop1", 4'h2, 3'h2, 16'h0802, 16'h0000);
    sk("pop0", 4'h2, 3'h2, 16'h0800, 16'h0000);
    sk("pop_udf", 4'h2, 3'h1, 16'h0000, 16'h0000);
    rd("stat_udf", `SLPA_OFS_STAT, 16'h0002);
    chk("irq_udf", irq, 1'b1);
    wr(`SLPA_OFS_CLR, 16'h0003);
    wr(`SLPA_OFS_LIMIT, 16'h0900);
    sk("call_lo", 4'h4, 3'h4, 16'h0800, 16'hBCDE);
    nx("call_hi", 16'h0802, 16'h007A);
    @(posedge clk);
    sk("exc_lo", 4'h8, 3'h4, 16'h0804, 16'hBCDE);
    nx("exc_hi", 16'h0806, 16'hC37A);
    @(posedge clk);
    wr(`SLPA_OFS_SP, 16'h07FE);
    sk("push_floor", 4'h1, 3'h1, 16'h0000, 16'h0000);
    rd("stat_floor", `SLPA_OFS_STAT, 16'h0002);
    rd("sp_floor", `SLPA_OFS_SP, 16'h07FE);
    wr(`SLPA_OFS_TABLE_PAGE_REG, 16'h0085);
    rd("tbl_rb", `SLPA_OFS_TABLE_PAGE_REG, 16'h0085);
    pg("tbl_cfg_rd", 3'h2, 16'h1235, 3'h5, 24'h851235);
    pg("tbl_cfg_wr", 3'h1, 16'h1235, 3'h0, 24'h000000);
    wr(`SLPA_OFS_TABLE_PAGE_REG, 16'h0005);
    pg("tbl_usr_wr", 3'h1, 16'h8001, 3'h2, 24'h058001);
    pg("win_off", 3'h4, 16'hC123, 3'h0, 24'h000000);
    wr(`SLPA_OFS_CORE, 16'h0004);
    rd("core_rb", `SLPA_OFS_CORE, 16'h0004);
    wr(`SLPA_OFS_VISPAG, 16'h0012);
    rd("vis_bad", `SLPA_OFS_VISPAG, 16'h0000);
    pg("win_pg0", 3'h4, 16'h8005, 3'h4, 24'h000005);
    pg("win_low", 3'h4, 16'h4123, 3'h0, 24'h000000);
    wr(`SLPA_OFS_VISPAG, 16'h00FF);
    rd("vis_ff", `SLPA_OFS_VISPAG, 16'h00FF);
    pg("win_ff", 3'h4, 16'hC123, 3'h4, 24'h7FC123);
    @(posedge clk);
    #1;
    chk("win_data", {win_valid, win_rdata}, {1'b1, 16'h3EDC});
    pg("win_susp", 3'h6, 16'hC123, 3'h4, 24'h05C123);
    @(posedge clk);
    #1;
    chk("win_susp_v", win_valid, 1'b0);
    chk("irq_floor", irq, 1'b1);
    // mid-run reset: pointer, flags, enables and window go back to idle
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    chk("irq_rerst", irq, 1'b0);
    rd("sp_rerst", `SLPA_OFS_SP, 16'h0800);
    rd("stat_rerst", `SLPA_OFS_STAT, 16'h0000);
    rd("core_rerst", `SLPA_OFS_CORE, 16'h0000);
    results();
  end
endmodule
